// ---- wsfg_pkg.sv ----
// constants for the wake source and fifo gate block
// ==========================================================
// Summary of operation
// - gate set: transition blocks fifo input, keeps contents, drops samples until emptied
// - gate set: sample arriving before fifo emptied sets gate overflow error
// - error holds while fifo unemptied, clears on empty; host empties to clear
// - transient detection wakes system only when its wake enable is one
// - orientation detection wakes system only when its wake enable is one
// - tap detection wakes system only when its wake enable is one
// - first freefall/motion channel wakes system only when enabled
// - second freefall/motion channel wakes system only when enabled
// - gate clear: fifo flushed on every wake/sleep mode change
package wsfg_pkg;

  // ==========================================================
  // register bus
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_MODE_STATUS = 8'h14;
  localparam logic [7:0] OFS_WAKE_CTRL = 8'h3a;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h41;

  // ==========================================================
  // wake control field positions
  localparam int unsigned BIT_FIFO_GATE = 7;
  localparam int unsigned BIT_TRANS_WAKE = 6;
  localparam int unsigned BIT_ORIENT_WAKE = 5;
  localparam int unsigned BIT_TAP_WAKE = 4;
  localparam int unsigned BIT_FFMT1_WAKE = 3;
  localparam int unsigned BIT_FFMT2_WAKE = 2;
  localparam logic [7:0] WAKE_CTRL_MASK = 8'hfc;
  localparam logic [7:0] WAKE_CTRL_RST = 8'h00;

  // ==========================================================
  // mode status field positions
  localparam int unsigned BIT_GATE_ERR = 7;
  localparam int unsigned BIT_GATE_ACTIVE = 1;
  localparam int unsigned BIT_WAKE_MODE = 0;

  // ==========================================================
  // interrupt status bits and reset values
  localparam int unsigned IRQ_N = 4;
  localparam int unsigned IRQ_WAKE_ENTER = 0;
  localparam int unsigned IRQ_SLEEP_ENTER = 1;
  localparam int unsigned IRQ_GATE_ERR = 2;
  localparam int unsigned IRQ_SAMPLE_DROP = 3;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  // ==========================================================
  // detection sources, index into the source vector
  localparam int unsigned SRC_N = 5;
  localparam int unsigned SRC_TRANS = 4;
  localparam int unsigned SRC_ORIENT = 3;
  localparam int unsigned SRC_TAP = 2;
  localparam int unsigned SRC_FFMT1 = 1;
  localparam int unsigned SRC_FFMT2 = 0;

  // ==========================================================
  // system mode
  typedef enum logic {MODE_WAKE, MODE_SLEEP} wsfg_mode_t;

endpackage

// ---- wsfg_wake_if.sv ----
// bundle between mode control and wake source selection
`timescale 1ns/1ps
interface wsfg_wake_if;
  logic [wsfg_pkg::SRC_N-1:0] det;
  logic [wsfg_pkg::SRC_N-1:0] en;
  logic sleeping;
  logic wake_req;

  // ==========================================================
  // selector side and controller side
  modport sel (
    input det,
    input en,
    input sleeping,
    output wake_req
  );
  modport ctl (
    output det,
    output en,
    output sleeping,
    input wake_req
  );
endinterface

// ---- wsfg_wake_sel.sv ----
// wake source selection: gates each detection by its enable
`timescale 1ns/1ps
module wsfg_wake_sel (
  wsfg_wake_if.sel wk
);
  logic [wsfg_pkg::SRC_N-1:0] gated;

  // ==========================================================
  // per source gate; disabled sources are masked out in sleep
  for (genvar i = 0; i < wsfg_pkg::SRC_N; i++) begin : g_src
    assign gated[i] = wk.det[i] & wk.en[i];
  end

  // any enabled source asks for wake while asleep
  assign wk.wake_req = wk.sleeping & (|gated);
endmodule

// ---- wsfg_top.sv ----
// wake source selection and fifo gate control
`timescale 1ns/1ps
module wsfg_top (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // register port
  input wire logic [wsfg_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [wsfg_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [wsfg_pkg::DATA_W-1:0] REG_RDATA,
  // detection interrupts, levels
  input wire logic DET_TRANS,
  input wire logic DET_ORIENT,
  input wire logic DET_TAP,
  input wire logic DET_FFMT1,
  input wire logic DET_FFMT2,
  // auto sleep request from the inactivity timer
  input wire logic SLEEP_REQ,
  // sample path to the fifo storage
  input wire logic SAMPLE_VALID,
  input wire logic FIFO_EMPTY,
  output logic FIFO_WR_EN,
  output logic FIFO_FLUSH,
  // mode and interrupt
  output logic WAKE_MODE,
  output logic IRQ
);

  // ==========================================================
  // declarations
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [wsfg_pkg::IRQ_N-1:0] mask_q;
  logic [wsfg_pkg::IRQ_N-1:0] mask_d;
  wsfg_pkg::wsfg_mode_t mode_q;
  wsfg_pkg::wsfg_mode_t mode_d;
  logic gate_q;
  logic gate_d;
  logic err_q;
  logic err_d;
  logic flush_q;
  logic flush_d;
  logic wr_en_q;
  logic wr_en_d;
  logic [wsfg_pkg::IRQ_N-1:0] ist_q;
  logic [wsfg_pkg::IRQ_N-1:0] ist_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic irq_q;
  logic irq_d;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_ist;
  logic mode_change;
  logic to_sleep;
  logic to_wake;
  logic gate_on;
  logic drop;
  logic err_rise;
  logic [wsfg_pkg::IRQ_N-1:0] ev;

  wsfg_wake_if wk ();

  // ==========================================================
  // wake source selection
  assign wk.det[wsfg_pkg::SRC_TRANS] = DET_TRANS;
  assign wk.det[wsfg_pkg::SRC_ORIENT] = DET_ORIENT;
  assign wk.det[wsfg_pkg::SRC_TAP] = DET_TAP;
  assign wk.det[wsfg_pkg::SRC_FFMT1] = DET_FFMT1;
  assign wk.det[wsfg_pkg::SRC_FFMT2] = DET_FFMT2;

  // enables come straight from the control register
  assign wk.en[wsfg_pkg::SRC_TRANS] = ctrl_q[wsfg_pkg::BIT_TRANS_WAKE];
  assign wk.en[wsfg_pkg::SRC_ORIENT] = ctrl_q[wsfg_pkg::BIT_ORIENT_WAKE];
  assign wk.en[wsfg_pkg::SRC_TAP] = ctrl_q[wsfg_pkg::BIT_TAP_WAKE];
  assign wk.en[wsfg_pkg::SRC_FFMT1] = ctrl_q[wsfg_pkg::BIT_FFMT1_WAKE];
  assign wk.en[wsfg_pkg::SRC_FFMT2] = ctrl_q[wsfg_pkg::BIT_FFMT2_WAKE];
  assign wk.sleeping = (mode_q == wsfg_pkg::MODE_SLEEP);

  wsfg_wake_sel u_sel (
    .wk(wk.sel)
  );

  // ==========================================================
  // register decode
  assign wr_ctrl = REG_WR && (REG_ADDR == wsfg_pkg::OFS_WAKE_CTRL);
  assign wr_mask = REG_WR && (REG_ADDR == wsfg_pkg::OFS_IRQ_MASK);
  assign rd_ist = REG_RD && (REG_ADDR == wsfg_pkg::OFS_IRQ_STATUS);

  // control and mask registers, next value
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    if (wr_ctrl) begin
      ctrl_d = REG_WDATA & wsfg_pkg::WAKE_CTRL_MASK;
    end
    if (wr_mask) begin
      mask_d = REG_WDATA[wsfg_pkg::IRQ_N-1:0];
    end
  end

  // control and mask registers, storage
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_q <= wsfg_pkg::WAKE_CTRL_RST;
      mask_q <= wsfg_pkg::IRQ_MASK_RST;
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
    end
  end

  // ==========================================================
  // system mode
  // sleep request wins only in wake; wake request only in sleep
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      wsfg_pkg::MODE_WAKE: begin
        if (SLEEP_REQ) begin
          mode_d = wsfg_pkg::MODE_SLEEP;
        end
      end
      wsfg_pkg::MODE_SLEEP: begin
        if (wk.wake_req) begin
          mode_d = wsfg_pkg::MODE_WAKE;
        end
      end
    endcase
  end

  // mode storage
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      mode_q <= wsfg_pkg::MODE_WAKE;
    end else begin
      mode_q <= mode_d;
    end
  end

  // transition strobes, one cycle, in the cycle before the new mode
  assign to_sleep = (mode_q == wsfg_pkg::MODE_WAKE) && (mode_d == wsfg_pkg::MODE_SLEEP);
  assign to_wake = (mode_q == wsfg_pkg::MODE_SLEEP) && (mode_d == wsfg_pkg::MODE_WAKE);
  assign mode_change = to_sleep || to_wake;
  assign gate_on = ctrl_q[wsfg_pkg::BIT_FIFO_GATE];

  // ==========================================================
  // fifo gate
  // gate closes on a mode change with gating on, opens once empty;
  // a sample while closed is dropped and, if still unemptied, errs
  always_comb begin
    gate_d = gate_q;
    err_d = err_q;
    flush_d = 1'b0;
    wr_en_d = 1'b0;
    drop = 1'b0;
    if (gate_q && FIFO_EMPTY) begin
      gate_d = 1'b0;
      err_d = 1'b0;
    end
    if (gate_q && SAMPLE_VALID) begin
      drop = 1'b1;
      if (!FIFO_EMPTY) begin
        err_d = 1'b1;
      end
    end else if (SAMPLE_VALID) begin
      wr_en_d = 1'b1;
    end
    // a sample on the transition edge never enters, gated or not
    if (mode_change) begin
      wr_en_d = 1'b0;
      drop = SAMPLE_VALID;
      if (gate_on) begin
        gate_d = 1'b1;
      end else begin
        flush_d = 1'b1;
      end
    end
  end

  // gate storage
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      gate_q <= 1'b0;
      err_q <= 1'b0;
      flush_q <= 1'b0;
      wr_en_q <= 1'b0;
    end else begin
      gate_q <= gate_d;
      err_q <= err_d;
      flush_q <= flush_d;
      wr_en_q <= wr_en_d;
    end
  end

  assign err_rise = err_d && !err_q;

  // ==========================================================
  // interrupt status, sticky; a read clears, a new event wins
  assign ev[wsfg_pkg::IRQ_WAKE_ENTER] = to_wake;
  assign ev[wsfg_pkg::IRQ_SLEEP_ENTER] = to_sleep;
  assign ev[wsfg_pkg::IRQ_GATE_ERR] = err_rise;
  assign ev[wsfg_pkg::IRQ_SAMPLE_DROP] = drop;

  always_comb begin
    ist_d = ist_q;
    if (rd_ist) begin
      ist_d = '0;
    end
    ist_d = ist_d | ev;
    irq_d = |(ist_d & mask_d);
  end

  // status and interrupt storage
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      ist_q <= '0;
      irq_q <= 1'b0;
    end else begin
      ist_q <= ist_d;
      irq_q <= irq_d;
    end
  end

  // ==========================================================
  // read data, one cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_d = 8'h00;
    if (REG_RD) begin
      unique case (REG_ADDR)
        wsfg_pkg::OFS_MODE_STATUS: begin
          rdata_d[wsfg_pkg::BIT_GATE_ERR] = err_q;
          rdata_d[wsfg_pkg::BIT_GATE_ACTIVE] = gate_q;
          rdata_d[wsfg_pkg::BIT_WAKE_MODE] = (mode_q == wsfg_pkg::MODE_WAKE);
        end
        wsfg_pkg::OFS_WAKE_CTRL: begin
          rdata_d = ctrl_q;
        end
        wsfg_pkg::OFS_IRQ_STATUS: begin
          rdata_d[wsfg_pkg::IRQ_N-1:0] = ist_q;
        end
        wsfg_pkg::OFS_IRQ_MASK: begin
          rdata_d[wsfg_pkg::IRQ_N-1:0] = mask_q;
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  // read data storage
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // outputs
  assign REG_RDATA = rdata_q;
  assign FIFO_WR_EN = wr_en_q;
  assign FIFO_FLUSH = flush_q;
  assign WAKE_MODE = (mode_q == wsfg_pkg::MODE_WAKE);
  assign IRQ = irq_q;

endmodule

// ---- wsfg_host_model.sv ----
// host side fifo model: fill count emptied by a host drain or a device flush
`timescale 1ns/1ps
module wsfg_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic flush,
  input wire logic drain,
  output logic empty
);
  logic [5:0] count_q;

  // ==========================================================
  // fill count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= 6'h00;
    end else if (flush || drain) begin
      count_q <= 6'h00;
    end else if (wr_en) begin
      count_q <= count_q + 6'h01;
    end
  end

  // empty flag seen by the device
  assign empty = (count_q == 6'h00);
endmodule

// ---- wsfg_top_props.sv ----
// concurrent checks on the ports of the wake source and fifo gate block
`timescale 1ns/1ps
module wsfg_top_props (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic DET_TRANS,
  input wire logic DET_ORIENT,
  input wire logic DET_TAP,
  input wire logic DET_FFMT1,
  input wire logic DET_FFMT2,
  input wire logic SLEEP_REQ,
  input wire logic SAMPLE_VALID,
  input wire logic FIFO_WR_EN,
  input wire logic FIFO_FLUSH,
  input wire logic WAKE_MODE
);
  logic any_det;

  // ==========================================================
  // single clock domain
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);

  // any detection line high
  assign any_det = DET_TRANS | DET_ORIENT | DET_TAP | DET_FFMT1 | DET_FFMT2;

  // ==========================================================
  // fifo write and flush
  chk_wr_from_sample: assert property (FIFO_WR_EN |-> $past(SAMPLE_VALID))
    else $error("fifo write without a sample");
  chk_no_wr_change: assert property (WAKE_MODE != $past(WAKE_MODE) |-> !FIFO_WR_EN)
    else $error("sample written on a mode change");
  chk_flush_cause: assert property (FIFO_FLUSH |-> WAKE_MODE != $past(WAKE_MODE))
    else $error("flush without a mode change");
  chk_flush_no_wr: assert property (FIFO_FLUSH |-> !FIFO_WR_EN)
    else $error("write beside a flush");

  // ==========================================================
  // mode control
  chk_sleep_enter: assert property (WAKE_MODE && SLEEP_REQ |=> !WAKE_MODE)
    else $error("sleep request ignored");
  chk_sleep_stays: assert property (!WAKE_MODE && !any_det |=> !WAKE_MODE)
    else $error("woke without a detection");
  chk_wake_cause: assert property ($rose(WAKE_MODE) |-> $past(any_det))
    else $error("wake not caused by a detection");

  // ==========================================================
  // read port
  chk_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 8'h00)
    else $error("read data outside a read");
  chk_mode_read: assert property (REG_RD && REG_ADDR == 8'h14 |=>
    REG_RDATA[0] == $past(WAKE_MODE) && REG_RDATA[6:2] == 5'h00)
    else $error("mode status layout wrong");
endmodule

bind wsfg_top wsfg_top_props i_wsfg_top_props (
  .CLK_SYS(CLK_SYS),
  .SYS_RST(SYS_RST),
  .REG_ADDR(REG_ADDR),
  .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA),
  .DET_TRANS(DET_TRANS),
  .DET_ORIENT(DET_ORIENT),
  .DET_TAP(DET_TAP),
  .DET_FFMT1(DET_FFMT1),
  .DET_FFMT2(DET_FFMT2),
  .SLEEP_REQ(SLEEP_REQ),
  .SAMPLE_VALID(SAMPLE_VALID),
  .FIFO_WR_EN(FIFO_WR_EN),
  .FIFO_FLUSH(FIFO_FLUSH),
  .WAKE_MODE(WAKE_MODE)
);

// ---- test_wsfg_top.sv ----
// self-checking bench for the wake source and fifo gate block
`timescale 1ns/1ps
module test_wsfg_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [4:0] det = 5'h00;
  logic sleep_req = 1'b0;
  logic sample = 1'b0;
  logic drain = 1'b0;
  logic [7:0] rdata;
  logic empty, wr_en, flush, wake, irq;
  logic [7:0] ra [5] = '{8'h14, 8'h3a, 8'h40, 8'h41, 8'h55};
  logic [7:0] re [5] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  int errors = 0;
  int tests_run = 0;

  // ==========================================================
  // design and host model
  wsfg_top i_wsfg_top (.CLK_SYS(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .DET_TRANS(det[4]), .DET_ORIENT(det[3]),
    .DET_TAP(det[2]), .DET_FFMT1(det[1]), .DET_FFMT2(det[0]), .SLEEP_REQ(sleep_req),
    .SAMPLE_VALID(sample), .FIFO_EMPTY(empty), .FIFO_WR_EN(wr_en), .FIFO_FLUSH(flush),
    .WAKE_MODE(wake), .IRQ(irq));
  wsfg_host_model i_wsfg_host_model (.clk(clk), .rst(rst), .wr_en(wr_en), .flush(flush),
    .drain(drain), .empty(empty));

  // clock, 40 ns period
  initial begin
    forever #20 clk = ~clk;
  end

  // ==========================================================
  // expectations, compare, bus and pulse tasks
  function automatic logic [7:0] mode_word(logic err, logic closed, logic wk);
    return {err, 5'b00000, closed, wk};
  endfunction

  task automatic check(string name, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // one-cycle pulses of sleep request, detections, sample and host drain
  task automatic step(logic s, logic [4:0] d, logic v, logic dr);
    @(posedge clk);
    sleep_req <= s;
    det <= d;
    sample <= v;
    drain <= dr;
    @(posedge clk);
    sleep_req <= 1'b0;
    det <= 5'h00;
    sample <= 1'b0;
    drain <= 1'b0;
    #1;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles of the run
  initial begin
    #400000;
    errors++;
    print_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] v;
    logic [7:0] r;
    void'($urandom(32'h1b4bcab2));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) begin
      reg_rd(ra[i], r);
      check("reset read", re[i], r);
    end
    reg_wr(8'h55, 8'hff);
    reg_rd(8'h55, r);
    check("unmapped read", 8'h00, r);
    repeat (16) begin
      v = 8'($urandom);
      reg_wr(8'h3a, v);
      reg_rd(8'h3a, r);
      check("wake ctrl", v & 8'hfc, r);
    end
    $display("test registers done");
    // gate closed on sleep entry with a filled fifo
    reg_wr(8'h3a, 8'h80);
    step(1'b0, 5'h00, 1'b0, 1'b1);
    repeat (3) begin
      step(1'b0, 5'h00, 1'b1, 1'b0);
      check("open write", 8'h01, 8'(wr_en));
    end
    step(1'b1, 5'h00, 1'b1, 1'b0);
    check("no flush", 8'h00, 8'(flush));
    check("transition drop", 8'h00, 8'(wr_en));
    step(1'b0, 5'h00, 1'b1, 1'b0);
    check("closed drop", 8'h00, 8'(wr_en));
    check("contents kept", 8'h00, 8'(empty));
    reg_rd(8'h14, r);
    check("gate error", mode_word(1'b1, 1'b1, 1'b0), r);
    step(1'b0, 5'h00, 1'b1, 1'b0);
    reg_rd(8'h14, r);
    check("error held", mode_word(1'b1, 1'b1, 1'b0), r);
    step(1'b0, 5'h00, 1'b0, 1'b1);
    reg_rd(8'h14, r);
    check("error cleared", mode_word(1'b0, 1'b0, 1'b0), r);
    step(1'b0, 5'h00, 1'b1, 1'b0);
    check("reopened write", 8'h01, 8'(wr_en));
    $display("test gate done");
    // gate bypassed: flush on both mode changes
    reg_wr(8'h3a, 8'h10);
    step(1'b0, 5'h04, 1'b0, 1'b0);
    check("wake flush", 8'h01, 8'(flush));
    @(posedge clk);
    #1 check("flushed", 8'h01, 8'(empty));
    repeat (20) begin
      repeat ($urandom_range(0, 3)) @(posedge clk);
      step(1'b0, 5'h00, 1'b1, 1'b0);
      check("bypass write", 8'h01, 8'(wr_en));
    end
    step(1'b1, 5'h00, 1'b1, 1'b0);
    check("sleep flush", 8'h01, 8'(flush));
    check("flush drop", 8'h00, 8'(wr_en));
    $display("test flush done");
    // each wake enable alone, against all other sources
    for (int k = 0; k < 5; k++) begin
      reg_wr(8'h3a, 8'h00);
      step(1'b1, 5'h00, 1'b0, 1'b0);
      step(1'b0, 5'h1f, 1'b0, 1'b0);
      check("all disabled", 8'h00, 8'(wake));
      reg_wr(8'h3a, 8'h04 << k);
      step(1'b0, ~(5'h01 << k), 1'b0, 1'b0);
      check("other sources", 8'h00, 8'(wake));
      step(1'b0, 5'h01 << k, 1'b0, 1'b0);
      check("enabled source", 8'h01, 8'(wake));
    end
    $display("test wake sources done");
    // interrupt raised, cleared by read, then masked
    reg_wr(8'h41, 8'h02);
    reg_rd(8'h41, r);
    check("irq mask", 8'h02, r);
    reg_rd(8'h40, r);
    check("status all events", 8'h0f, r);
    step(1'b1, 5'h00, 1'b0, 1'b0);
    check("irq raised", 8'h01, 8'(irq));
    reg_rd(8'h40, r);
    check("irq status", 8'h02, r);
    check("irq cleared", 8'h00, 8'(irq));
    reg_wr(8'h41, 8'h00);
    reg_wr(8'h3a, 8'h10);
    step(1'b0, 5'h04, 1'b0, 1'b0);
    check("irq masked", 8'h00, 8'(irq));
    reg_rd(8'h40, r);
    check("wake status", 8'h01, r);
    $display("test interrupt done");
    print_verdict();
  end
endmodule
